// ===== core/txlen_pkg.sv
// Package: register map, field layout and reset values of the transmit length registers
package txlen_pkg;
	// Printed offsets are not all multiples of four: they are register indexes
	localparam logic [7:0] TXLEN_IDX_HIGH = 8'h1d;
	localparam logic [7:0] TXLEN_IDX_LOW = 8'h1e;
	localparam int TXLEN_IDX_SHIFT = 2;
	// Own register: transmitter control and status
	localparam logic [7:0] TXLEN_IDX_CTRL = 8'h20;
	localparam logic [7:0] TXLEN_RESET = 8'h00;
	localparam int TXLEN_CTRL_START_BIT = 0;
	localparam int TXLEN_STAT_BUSY_BIT = 1;
	localparam int TXLEN_STAT_PARTIAL_BIT = 2;
	localparam int TXLEN_STAT_BITS_LSB = 4;
	localparam int TXLEN_COUNT_W = 12;
	localparam int TXLEN_BITS_W = 3;
	localparam int TXLEN_LOW_COUNT_LSB = 4;
	localparam int TXLEN_LOW_BITS_LSB = 1;
	localparam int TXLEN_LOW_FLAG_BIT = 0;
	localparam logic [1:0] TXLEN_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] TXLEN_HSIZE_WORD = 3'h2;
	localparam logic TXLEN_HRESP_OKAY = 1'b0;
	typedef enum logic [1:0] {TXLEN_IDLE, TXLEN_FULL, TXLEN_PART, TXLEN_EOF} txlen_state_t;
endpackage : txlen_pkg

// ===== core/txlen_sync.sv
// Module: three-stage synchroniser for the chip enable pin with agreement filter
`timescale 1ns/1ns
module txlen_sync
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pin_in,
	output logic level_out
);
	logic [2:0] stage_reg;
	logic [2:0] stage_next;
	logic level_reg;
	logic level_next;

	always_comb
	begin
		stage_next = {stage_reg[1:0], pin_in};
		level_next = level_reg;
		// Only stages two and three are compared; stage one is metastable
		if (stage_reg[1] == stage_reg[2])
		begin
			level_next = stage_reg[2];
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stage_reg <= 3'h0;
			level_reg <= 1'b0;
		end
		else
		begin
			stage_reg <= stage_next;
			level_reg <= level_next;
		end
	end

	assign level_out = level_reg;
endmodule : txlen_sync

// ===== core/txlen_top.sv
// Module: transmit length registers on AHB-Lite with the frame byte/bit sequencer
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ns
module txlen_top
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic chip_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic tx_ready,
	output logic tx_byte_req,
	output logic tx_bit_req,
	output logic tx_eof
);
	function automatic logic [31:0] reg_addr(input logic [7:0] idx);
		reg_addr = {22'h0, idx, 2'h0};
	endfunction : reg_addr

	// Field decode used only by the sequencer; the status read shows state_reg and bits_reg
	// Count field is split: high byte first, then the upper nibble of the low register
	function automatic logic [11:0] byte_count(input logic [7:0] hi, input logic [7:0] lo);
		byte_count = {hi, lo[7:txlen_pkg::TXLEN_LOW_COUNT_LSB]};
	endfunction : byte_count

	function automatic logic partial_flag(input logic [7:0] lo);
		partial_flag = lo[txlen_pkg::TXLEN_LOW_FLAG_BIT];
	endfunction : partial_flag

	// Bit count only matters with the flag set; otherwise it is taken as zero
	function automatic logic [2:0] partial_bits(input logic [7:0] lo);
		partial_bits = 3'h0;
		if (partial_flag(lo))
			partial_bits = lo[txlen_pkg::TXLEN_LOW_BITS_LSB +: txlen_pkg::TXLEN_BITS_W];
	endfunction : partial_bits

	////////////////////////////////////////////////////////////////////////
	// Enable pin is asynchronous: registers clear only once it has settled
	logic en_sync;
	txlen_sync u_en_sync
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in(chip_en),
		.level_out(en_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus slave: address phase captured, write applied in the data phase
	logic wr_pend_reg;
	logic wr_pend_next;
	logic [31:0] addr_reg;
	logic [31:0] addr_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [7:0] high_reg;
	logic [7:0] high_next;
	logic [7:0] low_reg;
	logic [7:0] low_next;
	txlen_pkg::txlen_state_t state_reg;
	txlen_pkg::txlen_state_t state_next;
	logic [11:0] cnt_reg;
	logic [11:0] cnt_next;
	logic [2:0] bits_reg;
	logic [2:0] bits_next;
	logic start;
	logic busy;
	logic addr_ok;

	assign busy = (state_reg != txlen_pkg::TXLEN_IDLE);
	assign addr_ok = hsel && hready && (htrans == txlen_pkg::TXLEN_HTRANS_NONSEQ)
		&& (hsize == txlen_pkg::TXLEN_HSIZE_WORD);
	assign start = wr_pend_reg && !busy
		&& addr_reg == reg_addr(txlen_pkg::TXLEN_IDX_CTRL)
		&& hwdata[txlen_pkg::TXLEN_CTRL_START_BIT];

	always_comb
	begin
		wr_pend_next = addr_ok && hwrite;
		addr_next = addr_ok ? haddr : addr_reg;
		rdata_next = 32'h0;
		if (addr_ok && !hwrite)
		begin
			if (haddr == reg_addr(txlen_pkg::TXLEN_IDX_HIGH))
				rdata_next = {24'h0, high_reg};
			else if (haddr == reg_addr(txlen_pkg::TXLEN_IDX_LOW))
				rdata_next = {24'h0, low_reg};
			else if (haddr == reg_addr(txlen_pkg::TXLEN_IDX_CTRL))
			begin
				rdata_next[txlen_pkg::TXLEN_STAT_BUSY_BIT] = busy;
				rdata_next[txlen_pkg::TXLEN_STAT_PARTIAL_BIT] = (state_reg == txlen_pkg::TXLEN_PART);
				// Bit count of the partial byte shows only while that byte is sent
				if (state_reg == txlen_pkg::TXLEN_PART)
					rdata_next[txlen_pkg::TXLEN_STAT_BITS_LSB +: txlen_pkg::TXLEN_BITS_W] = bits_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Length registers
	always_comb
	begin
		high_next = high_reg;
		low_next = low_reg;
		// Writes are refused while a frame runs so the count cannot shift under it
		if (wr_pend_reg && !busy)
		begin
			if (addr_reg == reg_addr(txlen_pkg::TXLEN_IDX_HIGH))
				high_next = hwdata[7:0];
			else if (addr_reg == reg_addr(txlen_pkg::TXLEN_IDX_LOW))
				low_next = hwdata[7:0];
		end
		if (state_reg == txlen_pkg::TXLEN_EOF)
		begin
			high_next = txlen_pkg::TXLEN_RESET;
			low_next = txlen_pkg::TXLEN_RESET;
		end
		if (!en_sync)
		begin
			high_next = txlen_pkg::TXLEN_RESET;
			low_next = txlen_pkg::TXLEN_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame sequencer: one request per accepted byte or partial byte
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		bits_next = bits_reg;
		tx_byte_req = 1'b0;
		tx_bit_req = 1'b0;
		unique case (state_reg)
			txlen_pkg::TXLEN_IDLE:
			begin
				if (start)
				begin
					// Latched here so a late write cannot reshape a running frame
					cnt_next = byte_count(high_reg, low_reg);
					bits_next = partial_bits(low_reg);
					if (cnt_next != 12'h000)
						state_next = txlen_pkg::TXLEN_FULL;
					else if (partial_flag(low_reg))
						state_next = txlen_pkg::TXLEN_PART;
					else
						state_next = txlen_pkg::TXLEN_EOF;
				end
			end
			txlen_pkg::TXLEN_FULL:
			begin
				tx_byte_req = 1'b1;
				if (tx_ready)
				begin
					cnt_next = cnt_reg - 12'h001;
					if (cnt_reg == 12'h001)
						state_next = partial_flag(low_reg)
							? txlen_pkg::TXLEN_PART : txlen_pkg::TXLEN_EOF;
				end
			end
			txlen_pkg::TXLEN_PART:
			begin
				tx_bit_req = 1'b1;
				if (tx_ready)
					state_next = txlen_pkg::TXLEN_EOF;
			end
			txlen_pkg::TXLEN_EOF:
			begin
				state_next = txlen_pkg::TXLEN_IDLE;
			end
		endcase
		// Disable abandons a frame at once, with no end-of-frame pulse
		if (!en_sync)
			state_next = txlen_pkg::TXLEN_IDLE;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 32'h0;
			rdata_reg <= 32'h0;
			high_reg <= txlen_pkg::TXLEN_RESET;
			low_reg <= txlen_pkg::TXLEN_RESET;
			state_reg <= txlen_pkg::TXLEN_IDLE;
			cnt_reg <= 12'h000;
			bits_reg <= 3'h0;
		end
		else
		begin
			wr_pend_reg <= wr_pend_next;
			addr_reg <= addr_next;
			rdata_reg <= rdata_next;
			high_reg <= high_next;
			low_reg <= low_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			bits_reg <= bits_next;
		end
	end

	assign hrdata = rdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = txlen_pkg::TXLEN_HRESP_OKAY;
	assign tx_eof = (state_reg == txlen_pkg::TXLEN_EOF);
endmodule : txlen_top

// ===== verification/txlen_monitor.sv
// Checker: port-level assertions of the transmit length block
`timescale 1ns/1ns
module txlen_monitor
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [31:0] hrdata,
	input wire logic tx_ready,
	input wire logic tx_byte_req,
	input wire logic tx_bit_req,
	input wire logic tx_eof
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////////////
	property p_rst; $fell(sys_rst) |-> hrdata == 32'h0 && !tx_byte_req && !tx_bit_req; endproperty
	a_rst: assert property (p_rst) else $error("outputs active after reset");
	property p_eof_pulse; tx_eof |=> !tx_eof; endproperty
	a_eof_pulse: assert property (p_eof_pulse) else $error("end of frame too long");
	property p_eof_quiet; tx_eof |-> (!tx_byte_req && !tx_bit_req) [*2]; endproperty
	a_eof_quiet: assert property (p_eof_quiet) else $error("request after frame end");
	property p_width; hrdata[31:8] == 24'h0; endproperty
	a_width: assert property (p_width) else $error("upper read bits set");
	property p_one; !(tx_byte_req && tx_bit_req); endproperty
	a_one: assert property (p_one) else $error("byte and bit request together");
	property p_bit_hold; tx_bit_req && !tx_ready |=> tx_bit_req; endproperty
	a_bit_hold: assert property (p_bit_hold) else $error("partial request dropped");
	property p_byte_hold; tx_byte_req && !tx_ready |=> tx_byte_req; endproperty
	a_byte_hold: assert property (p_byte_hold) else $error("byte request dropped");
	property p_bit_end; tx_bit_req && tx_ready |=> tx_eof; endproperty
	a_bit_end: assert property (p_bit_end) else $error("no frame end after partial");
endmodule : txlen_monitor

// ===== verification/txlen_top_test.sv
// Testbench: self-checking bench of the transmit length registers
`timescale 1ns/1ns
module txlen_top_test;
	logic clk, sys_rst, chip_en, hwrite, tx_ready, hreadyout, hresp, tx_byte_req, tx_bit_req, tx_eof;
	logic [31:0] haddr, hwdata, hrdata, s, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] hi, lo;
	int failures, samples_checked, nb, nk, j, kind, ne, mh, ml, men, mbusy;
	int exp_q[$];
	logic done;
	txlen_top dut_u (.clk(clk), .sys_rst(sys_rst), .chip_en(chip_en), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.tx_ready(tx_ready), .tx_byte_req(tx_byte_req), .tx_bit_req(tx_bit_req), .tx_eof(tx_eof));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d);
		haddr <= {22'h0, idx, 2'h0};
		htrans <= txlen_pkg::TXLEN_HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= txlen_pkg::TXLEN_HSIZE_WORD;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk({31'h0, hresp}, {31'h0, txlen_pkg::TXLEN_HRESP_OKAY});
	endtask : bus
	task automatic rd(input logic [7:0] idx, input int e);
		bus(idx, 1'b0, 8'h0);
		chk(q, e);
	endtask : rd
	// Model keeps the registers; writes land only when enabled and idle
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
		if (men == 1 && mbusy == 0 && idx == txlen_pkg::TXLEN_IDX_HIGH)
			mh = d;
		if (men == 1 && mbusy == 0 && idx == txlen_pkg::TXLEN_IDX_LOW)
			ml = d;
	endtask : wr
	function automatic int stat_exp();
		stat_exp = 1 << txlen_pkg::TXLEN_STAT_BUSY_BIT;
		if (ne == 0 && ml % 2 == 1)
			stat_exp += (1 << txlen_pkg::TXLEN_STAT_PARTIAL_BIT)
				+ (((ml / 2) % 8) << txlen_pkg::TXLEN_STAT_BITS_LSB);
	endfunction : stat_exp
	task automatic frame(input logic [7:0] h, input logic [7:0] l, input logic busy_chk);
		tx_ready <= 1'b0;
		wr(txlen_pkg::TXLEN_IDX_HIGH, h);
		wr(txlen_pkg::TXLEN_IDX_LOW, l);
		ne = mh * 16 + ml / 16;
		exp_q = {};
		for (int i = 0; i < ne; i++)
			exp_q.push_back(0);
		if (ml % 2 == 1)
			exp_q.push_back(1);
		bus(txlen_pkg::TXLEN_IDX_CTRL, 1'b1, 8'h01);
		mbusy = 1;
		// Transmitter held off so the frame is still running here
		if (busy_chk)
		begin
			rd(txlen_pkg::TXLEN_IDX_CTRL, stat_exp());
			wr(txlen_pkg::TXLEN_IDX_HIGH, 8'h77);
			rd(txlen_pkg::TXLEN_IDX_HIGH, mh);
		end
		done = 1'b0;
		nb = 0;
		nk = 0;
		for (int i = 0; i < 4000 && !done; i++)
		begin
			@(posedge clk);
			nb += int'(tx_byte_req & tx_ready);
			nk += int'(tx_bit_req & tx_ready);
			if ((tx_byte_req | tx_bit_req) & tx_ready)
			begin
				kind = (exp_q.size() > 0) ? exp_q.pop_front() : 2;
				chk({31'h0, tx_bit_req}, kind);
			end
			done = (tx_eof === 1'b1);
			tx_ready <= s[3];
			void'(xs());
		end
		chk({31'h0, done}, 32'h1);
		chk(exp_q.size(), 0);
		chk(nb, ne);
		chk(nk, ml % 2);
		mbusy = 0;
		mh = 0;
		ml = 0;
		rd(txlen_pkg::TXLEN_IDX_HIGH, mh);
		rd(txlen_pkg::TXLEN_IDX_LOW, ml);
	endtask : frame
	task automatic finish_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#500000;
		failures++;
		finish_test();
	end
	initial
	begin
		{sys_rst, chip_en, s} = {2'b11, 32'd97};
		{haddr, hwdata, htrans, hwrite, hsize, tx_ready} = '0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		// Enable must clear the synchroniser first or writes are lost
		repeat (6) @(posedge clk);
		{men, mbusy, mh, ml} = {32'd1, 32'd0, 32'd0, 32'd0};
		rd(txlen_pkg::TXLEN_IDX_HIGH, mh);
		for (j = 0; j < 6; j++)
		begin
			void'(xs());
			hi = s[7:0];
			void'(xs());
			lo = s[15:8];
			wr(txlen_pkg::TXLEN_IDX_HIGH, hi);
			wr(txlen_pkg::TXLEN_IDX_LOW, lo);
			rd(txlen_pkg::TXLEN_IDX_HIGH, mh);
			rd(txlen_pkg::TXLEN_IDX_LOW, ml);
		end
		frame(8'h00, 8'h00, 1'b0);
		frame(8'h00, 8'h2f, 1'b1);
		frame(8'h00, 8'h0b, 1'b1);
		frame(8'h01, 8'hf0, 1'b0);
		frame(8'h00, {4'h3, lo[2:0], 1'b0}, 1'b0);
		frame({4'h0, hi[3:0]}, lo, 1'b0);
		wr(txlen_pkg::TXLEN_IDX_HIGH, 8'h5a);
		chip_en <= 1'b0;
		repeat (6) @(posedge clk);
		{men, mh, ml} = {32'd0, 32'd0, 32'd0};
		wr(txlen_pkg::TXLEN_IDX_HIGH, 8'h3c);
		rd(txlen_pkg::TXLEN_IDX_HIGH, mh);
		chip_en <= 1'b1;
		repeat (6) @(posedge clk);
		men = 1;
		rd(txlen_pkg::TXLEN_IDX_HIGH, mh);
		wr(txlen_pkg::TXLEN_IDX_HIGH, 8'ha5);
		// Second reset in mid-run must clear a written register
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		{mh, ml} = {32'd0, 32'd0};
		repeat (6) @(posedge clk);
		rd(txlen_pkg::TXLEN_IDX_HIGH, mh);
		rd(8'h1f, 8'h00);
		finish_test();
	end
endmodule : txlen_top_test
bind txlen_top txlen_monitor mon_u (.clk(clk), .sys_rst(sys_rst), .hrdata(hrdata),
	.tx_ready(tx_ready), .tx_byte_req(tx_byte_req), .tx_bit_req(tx_bit_req), .tx_eof(tx_eof));
